// file: hdl/dcdp_port.sv
// Daisy-chain data port: APB registers, own-sample FIFO and chain sequencer.
//
// Summary of operation
// - Source-only mode sends own words only; upstream data is never taken.
// - Trailing mode forwards the whole upstream block, then appends own words.
// - Leading mode sends own words first, then forwards the upstream block.
// - Relay mode, the reset mode, forwards upstream words and adds nothing.
// - The chain mode acts only while output is routed to the chain.
// - Routing and mode share the control register; every routing write also loads the mode field.
// - Writing a different mode aborts the measurement; same value keeps it running.
// - Entering chain reset flags that the whole chain must be resequenced.
// - Chain reset hold stops the interface while set; it is set after reset.
`timescale 1ns/10ps
module dcdp_port (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// APB slave.
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Own samples from the acquisition logic.
	input wire logic sample_valid_in,
	input wire logic [31:0] sample_data_in,
	output logic sample_ready_out,
	// Upstream chain from the left neighbour.
	input wire logic up_valid_in,
	input wire logic [31:0] up_data_in,
	input wire logic up_last_in,
	output logic up_ready_out,
	// Downstream chain to the right neighbour.
	output logic dn_valid_out,
	output logic [31:0] dn_data_out,
	output logic dn_last_out,
	input wire logic dn_ready_in,
	// Backplane data port.
	output logic bp_valid_out,
	output logic [31:0] bp_data_out,
	input wire logic bp_ready_in,
	// Chain status.
	output logic chain_hold_out,
	output logic chain_resync_out
);
	// Register state.
	logic [1:0] chain_mode_select;
	logic to_chain;
	logic chain_reset_hold;
	logic [15:0] blk_len;
	logic meas_run;
	logic abort_seen;
	logic resync_req;

	// Sequencer state.
	dcdp_pkg::dcdp_state_t state;
	dcdp_pkg::dcdp_state_t next_state;
	logic [1:0] blk_mode;
	logic [15:0] own_cnt;
	logic up_buf_valid;
	logic [31:0] up_buf_data;
	logic up_buf_last;

	// FIFO wires.
	logic fifo_valid;
	logic [31:0] fifo_data;
	logic fifo_full;
	logic fifo_empty;

	// APB decode.
	wire apb_access = psel_in & penable_in & pready_out;
	wire apb_wr = apb_access & pwrite_in;
	wire sel_ctrl = (paddr_in == dcdp_pkg::DCDP_ADDR_CTRL);
	wire sel_status = (paddr_in == dcdp_pkg::DCDP_ADDR_STATUS);
	wire sel_blklen = (paddr_in == dcdp_pkg::DCDP_ADDR_BLKLEN);
	wire addr_hit = sel_ctrl | sel_status | sel_blklen;
	wire wr_ctrl = apb_wr & sel_ctrl;
	wire wr_status = apb_wr & sel_status;
	wire wr_blklen = apb_wr & sel_blklen;
	wire [1:0] wr_mode = pwdata_in[dcdp_pkg::DCDP_CTRL_MODE_MSB:dcdp_pkg::DCDP_CTRL_MODE_LSB];
	wire mode_change = wr_ctrl & (wr_mode != chain_mode_select);
	wire wr_hold = pwdata_in[dcdp_pkg::DCDP_CTRL_RST_HOLD];
	wire hold_rise = wr_ctrl & wr_hold & ~chain_reset_hold;

	// Read mux.
	wire [31:0] rd_ctrl = {26'h000_0000, 2'h0, chain_reset_hold, to_chain, chain_mode_select};
	wire [31:0] rd_status = {27'h000_0000, fifo_full, fifo_empty, resync_req, abort_seen,
		meas_run};
	wire [31:0] rd_blklen = {16'h0000, blk_len};
	wire [31:0] rd_mux = sel_ctrl ? rd_ctrl : sel_status ? rd_status :
		sel_blklen ? rd_blklen : 32'h0000_0000;

	// Path conditions.
	wire chain_active = to_chain & ~chain_reset_hold;
	wire dn_free = ~dn_valid_out | dn_ready_in;
	wire bp_free = ~bp_valid_out | bp_ready_in;
	wire [15:0] len_eff = (blk_len == 16'h0000) ? dcdp_pkg::DCDP_LEN_ONE : blk_len;
	wire own_final = (own_cnt == len_eff - dcdp_pkg::DCDP_LEN_ONE);
	wire own_take = (state == dcdp_pkg::DCDP_ST_OWN) & chain_active & fifo_valid & dn_free;
	wire up_take = (state == dcdp_pkg::DCDP_ST_UP) & chain_active & up_buf_valid & dn_free;
	wire bp_take = ~to_chain & meas_run & fifo_valid & bp_free;
	wire up_push = up_ready_out & up_valid_in;
	wire next_buf_valid = (up_buf_valid & ~up_take) | up_push;
	// Own words end the block except in leading mode, where the upstream block follows.
	wire own_last = own_final & (blk_mode != dcdp_pkg::DCDP_MODE_LEADING);
	// In trailing mode the upstream end marker is held back for the appended words.
	wire up_last = up_buf_last & (blk_mode != dcdp_pkg::DCDP_MODE_TRAILING);

	dcdp_fifo #(
		.WIDTH(dcdp_pkg::DCDP_DATA_W),
		.DEPTH(dcdp_pkg::DCDP_FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.resetn_in(resetn_in),
		.in_valid_in(sample_valid_in),
		.in_data_in(sample_data_in),
		.in_ready_out(sample_ready_out),
		.out_valid_out(fifo_valid),
		.out_data_out(fifo_data),
		.out_ready_in(own_take | bp_take),
		.full_out(fifo_full),
		.empty_out(fifo_empty)
	);

	// APB slave: one wait state, so pready rises in the second access-phase cycle.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			pready_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			pslverr_out <= 1'b0;
		end
		else
		begin
			pready_out <= psel_in & penable_in & ~pready_out;
			prdata_out <= rd_mux;
			pslverr_out <= psel_in & penable_in & ~pready_out & ~addr_hit;
		end
	end

	// Control registers; every control write loads the mode field together with routing and hold.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			chain_mode_select <= dcdp_pkg::DCDP_RST_MODE;
			to_chain <= dcdp_pkg::DCDP_RST_TO_CHAIN;
			chain_reset_hold <= dcdp_pkg::DCDP_RST_HOLD;
			blk_len <= dcdp_pkg::DCDP_RST_BLKLEN;
		end
		else
		begin
			if (wr_ctrl)
			begin
				chain_mode_select <= wr_mode;
				to_chain <= pwdata_in[dcdp_pkg::DCDP_CTRL_TO_CHAIN];
				chain_reset_hold <= wr_hold;
			end
			if (wr_blklen)
				blk_len <= pwdata_in[15:0];
		end
	end

	// Measurement state. A mode change beats a start in the same write.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			meas_run <= 1'b0;
			abort_seen <= 1'b0;
		end
		else
		begin
			if (mode_change)
				meas_run <= 1'b0;
			else if (wr_ctrl & pwdata_in[dcdp_pkg::DCDP_CTRL_STOP])
				meas_run <= 1'b0;
			else if (wr_ctrl & pwdata_in[dcdp_pkg::DCDP_CTRL_START])
				meas_run <= 1'b1;
			if (mode_change & meas_run)
				abort_seen <= 1'b1;
			else if (wr_status & pwdata_in[dcdp_pkg::DCDP_STAT_ABORT])
				abort_seen <= 1'b0;
		end
	end

	// The resequence flag powers up set, since power-up also needs the ordered sequence.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
			resync_req <= 1'b1;
		else if (hold_rise)
			resync_req <= 1'b1;
		else if (wr_status & pwdata_in[dcdp_pkg::DCDP_STAT_RESYNC])
			resync_req <= 1'b0;
	end

	// Block sequencer.
	always_comb
	begin
		next_state = state;
		case (state)
			dcdp_pkg::DCDP_ST_IDLE:
			begin
				if (chain_active & (chain_mode_select == dcdp_pkg::DCDP_MODE_RELAY))
				begin
					// Relay starts only with a word in hand, so a later mode write is never stuck.
					if (up_buf_valid)
						next_state = dcdp_pkg::DCDP_ST_UP;
				end
				else if (chain_active & meas_run &
					(chain_mode_select == dcdp_pkg::DCDP_MODE_TRAILING))
					next_state = dcdp_pkg::DCDP_ST_UP;
				else if (chain_active & meas_run)
					next_state = dcdp_pkg::DCDP_ST_OWN;
			end
			dcdp_pkg::DCDP_ST_OWN:
			begin
				if (~chain_active | ~meas_run)
					next_state = dcdp_pkg::DCDP_ST_IDLE;
				else if (own_take & own_final & (blk_mode == dcdp_pkg::DCDP_MODE_LEADING))
					next_state = dcdp_pkg::DCDP_ST_UP;
				else if (own_take & own_final)
					next_state = dcdp_pkg::DCDP_ST_IDLE;
			end
			dcdp_pkg::DCDP_ST_UP:
			begin
				if (~chain_active)
					next_state = dcdp_pkg::DCDP_ST_IDLE;
				else if (up_take & up_buf_last & (blk_mode == dcdp_pkg::DCDP_MODE_TRAILING))
					next_state = dcdp_pkg::DCDP_ST_OWN;
				else if (up_take & up_buf_last)
					next_state = dcdp_pkg::DCDP_ST_IDLE;
			end
			default:
				next_state = dcdp_pkg::DCDP_ST_IDLE;
		endcase
	end

	// The block mode is latched at block start so a mid-block write cannot mix sources.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			state <= dcdp_pkg::DCDP_ST_IDLE;
			blk_mode <= dcdp_pkg::DCDP_RST_MODE;
			own_cnt <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			if (state == dcdp_pkg::DCDP_ST_IDLE)
				blk_mode <= chain_mode_select;
			if (state != dcdp_pkg::DCDP_ST_OWN)
				own_cnt <= 16'h0000;
			else if (own_take)
				own_cnt <= own_final ? 16'h0000 : own_cnt + dcdp_pkg::DCDP_LEN_ONE;
		end
	end

	// Upstream buffer; source-only blocks never accept upstream words.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			up_buf_valid <= 1'b0;
			up_buf_data <= 32'h0000_0000;
			up_buf_last <= 1'b0;
			up_ready_out <= 1'b0;
		end
		else
		begin
			up_buf_valid <= next_buf_valid & ~chain_reset_hold;
			if (up_push)
			begin
				up_buf_data <= up_data_in;
				up_buf_last <= up_last_in;
			end
			up_ready_out <= ~next_buf_valid & chain_active &
				(chain_mode_select != dcdp_pkg::DCDP_MODE_SOURCE);
		end
	end

	// Output registers for the chain and the backplane.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			dn_valid_out <= 1'b0;
			dn_data_out <= 32'h0000_0000;
			dn_last_out <= 1'b0;
			bp_valid_out <= 1'b0;
			bp_data_out <= 32'h0000_0000;
			chain_hold_out <= 1'b1;
			chain_resync_out <= 1'b1;
		end
		else
		begin
			if (chain_reset_hold)
				dn_valid_out <= 1'b0;
			else if (own_take | up_take)
			begin
				dn_valid_out <= 1'b1;
				dn_data_out <= own_take ? fifo_data : up_buf_data;
				dn_last_out <= own_take ? own_last : up_last;
			end
			else if (dn_ready_in)
				dn_valid_out <= 1'b0;
			if (bp_take)
			begin
				bp_valid_out <= 1'b1;
				bp_data_out <= fifo_data;
			end
			else if (bp_ready_in)
				bp_valid_out <= 1'b0;
			chain_hold_out <= chain_reset_hold;
			chain_resync_out <= resync_req;
		end
	end

	default clocking dcdp_cb @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	source_no_up_a: assert property ((blk_mode == dcdp_pkg::DCDP_MODE_SOURCE) &&
		state != dcdp_pkg::DCDP_ST_IDLE |-> !up_take)
		else $error("upstream word forwarded in source-only block");
	trailing_order_a: assert property (up_take && up_buf_last &&
		blk_mode == dcdp_pkg::DCDP_MODE_TRAILING && chain_active
		|=> state == dcdp_pkg::DCDP_ST_OWN)
		else $error("own words did not follow upstream block in trailing mode");
	leading_order_a: assert property (own_take && own_final &&
		blk_mode == dcdp_pkg::DCDP_MODE_LEADING && meas_run
		|=> state == dcdp_pkg::DCDP_ST_UP && !dn_last_out)
		else $error("upstream block did not follow own words in leading mode");
	relay_no_own_a: assert property (blk_mode == dcdp_pkg::DCDP_MODE_RELAY &&
		state == dcdp_pkg::DCDP_ST_UP |-> !own_take)
		else $error("own word sent in relay mode");
	route_gate_a: assert property (!to_chain |=> !own_take && !up_take)
		else $error("chain path used while routed to backplane");
	mode_keep_a: assert property (!wr_ctrl |=> $stable(chain_mode_select))
		else $error("chain mode changed without a control write");
	abort_on_change_a: assert property (mode_change |=> !meas_run)
		else $error("measurement kept running after mode change");
	same_mode_run_a: assert property (wr_ctrl && !mode_change && meas_run &&
		!pwdata_in[dcdp_pkg::DCDP_CTRL_STOP] |=> meas_run)
		else $error("rewriting the same mode stopped the measurement");
	resync_set_a: assert property (hold_rise |=> resync_req ##1 chain_resync_out)
		else $error("entering chain reset did not flag resequencing");
	hold_quiet_a: assert property (chain_reset_hold |=>
		!dn_valid_out && !up_ready_out)
		else $error("chain interface active while held in reset");
	no_interleave_a: assert property (state == dcdp_pkg::DCDP_ST_UP && !up_take &&
		chain_active |=> !own_take)
		else $error("own word entered an upstream stretch");

	trailing_seen_c: cover property (up_take && up_buf_last &&
		blk_mode == dcdp_pkg::DCDP_MODE_TRAILING ##[1:20] own_take && own_last);
	leading_seen_c: cover property (own_take && own_final &&
		blk_mode == dcdp_pkg::DCDP_MODE_LEADING ##[1:20] up_take && up_buf_last);
	abort_seen_c: cover property (mode_change && meas_run);
	fifo_full_c: cover property (fifo_full && sample_valid_in);
endmodule : dcdp_port

// file: hdl/dcdp_pkg.sv
// Package with register map, field layout and encodings of the daisy-chain data port.
package dcdp_pkg;
	localparam int DCDP_DATA_W = 32;
	localparam int DCDP_FIFO_DEPTH = 16;
	localparam int DCDP_ADDR_W = 12;
	localparam int DCDP_LEN_W = 16;

	// Register byte offsets.
	localparam logic [11:0] DCDP_ADDR_CTRL = 12'h000;
	localparam logic [11:0] DCDP_ADDR_STATUS = 12'h004;
	localparam logic [11:0] DCDP_ADDR_BLKLEN = 12'h008;

	// Control register fields.
	localparam int DCDP_CTRL_MODE_LSB = 0;
	localparam int DCDP_CTRL_MODE_MSB = 1;
	localparam int DCDP_CTRL_TO_CHAIN = 2;
	localparam int DCDP_CTRL_RST_HOLD = 3;
	localparam int DCDP_CTRL_START = 4;
	localparam int DCDP_CTRL_STOP = 5;

	// Status register fields.
	localparam int DCDP_STAT_RUN = 0;
	localparam int DCDP_STAT_ABORT = 1;
	localparam int DCDP_STAT_RESYNC = 2;
	localparam int DCDP_STAT_FIFO_EMPTY = 3;
	localparam int DCDP_STAT_FIFO_FULL = 4;

	// Chain mode encodings.
	localparam logic [1:0] DCDP_MODE_SOURCE = 2'h0;
	localparam logic [1:0] DCDP_MODE_TRAILING = 2'h1;
	localparam logic [1:0] DCDP_MODE_LEADING = 2'h2;
	localparam logic [1:0] DCDP_MODE_RELAY = 2'h3;

	// Reset values.
	localparam logic [1:0] DCDP_RST_MODE = DCDP_MODE_RELAY;
	localparam logic DCDP_RST_TO_CHAIN = 1'b0;
	localparam logic DCDP_RST_HOLD = 1'b1;
	localparam logic [15:0] DCDP_RST_BLKLEN = 16'h0010;
	localparam logic [15:0] DCDP_LEN_ONE = 16'h0001;

	typedef enum logic [1:0] {DCDP_ST_IDLE, DCDP_ST_OWN, DCDP_ST_UP} dcdp_state_t;
endpackage : dcdp_pkg

// file: hdl/dcdp_fifo.sv
// Parameterised synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
module dcdp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Filling side.
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	// Draining side.
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in,
	// Fill state.
	output logic full_out,
	output logic empty_out
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W:0] CNT_DEPTH = (PTR_W+1)'(DEPTH);
	localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic [PTR_W:0] count;
	logic [PTR_W:0] next_count;
	wire push = in_valid_in & in_ready_out;
	wire pop = out_valid_out & out_ready_in;

	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		ptr_inc = (p == PTR_LAST) ? '0 : p + 1'b1;
	endfunction : ptr_inc

	assign next_count = count + (push ? CNT_ONE : '0) - (pop ? CNT_ONE : '0);
	assign out_valid_out = ~empty_out;
	assign out_data_out = mem[rd_ptr];

	// Ready is registered from the next count, so it drops in the same cycle that full rises, never late.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready_out <= 1'b1;
			full_out <= 1'b0;
			empty_out <= 1'b1;
		end
		else
		begin
			if (push)
				wr_ptr <= ptr_inc(wr_ptr);
			if (pop)
				rd_ptr <= ptr_inc(rd_ptr);
			count <= next_count;
			in_ready_out <= (next_count != CNT_DEPTH);
			full_out <= (next_count == CNT_DEPTH);
			empty_out <= (next_count == '0);
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wr_ptr] <= in_data_in;
	end
endmodule : dcdp_fifo

// file: verification/dcdp_chain_model.sv
// Behavioural left and right neighbours of the chain port.
`timescale 1ns/10ps
module dcdp_chain_model (
	// Clock and reset.
	input wire logic clk_in,
	input wire logic resetn_in,
	// Block request from the bench.
	input wire logic go_in,
	input wire logic [7:0] cnt_in,
	input wire logic [31:0] base_in,
	input wire logic slow_in,
	// Upstream side.
	output logic up_valid_out,
	output logic [31:0] up_data_out,
	output logic up_last_out,
	input wire logic up_ready_in,
	// Downstream side.
	input wire logic dn_valid_in,
	input wire logic [31:0] dn_data_in,
	input wire logic dn_last_in,
	output logic dn_ready_out
);
	logic [7:0] left;
	logic [32:0] got [0:31];
	int n_got;

	// Released data shows the inverse of the last word, so a stale word never looks valid.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			up_valid_out <= 1'b0;
			up_data_out <= 32'hFFFF_FFFF;
			up_last_out <= 1'b0;
			left <= 8'h00;
		end
		else if (go_in)
		begin
			up_valid_out <= 1'b1;
			up_data_out <= base_in;
			up_last_out <= (cnt_in == 8'h01);
			left <= cnt_in;
		end
		else if (up_valid_out && up_ready_in)
		begin
			up_valid_out <= (left != 8'h01);
			up_data_out <= (left == 8'h01) ? ~up_data_out : up_data_out + 32'h0000_0001;
			up_last_out <= (left == 8'h02);
			left <= left - 8'h01;
		end
	end

	// A slow sink stalls every other cycle to expose hold faults on the output.
	always_ff @(posedge clk_in)
	begin
		if (!resetn_in)
		begin
			dn_ready_out <= 1'b0;
			n_got <= 0;
		end
		else
		begin
			dn_ready_out <= slow_in ? ~dn_ready_out : 1'b1;
			if (dn_valid_in && dn_ready_out)
			begin
				got[n_got] <= {dn_last_in, dn_data_in};
				n_got <= n_got + 1;
			end
		end
	end
endmodule : dcdp_chain_model

// file: verification/tb_top.sv
// Self-checking testbench of the daisy-chain data port.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
	logic clk_in, resetn_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, sample_data_in, up_data, dn_data, bp_data, base, rdata;
	logic sample_valid_in, sample_ready_out, up_valid, up_last, up_ready, dn_valid, dn_last;
	logic dn_ready, bp_valid, bp_ready, hold_out, resync_out, go, slow, rerr;
	logic [7:0] cnt;
	logic [31:0] bp_q [$];
	int miscompares = 0;
	int n_tests = 0;
	localparam logic [11:0] CTRL = dcdp_pkg::DCDP_ADDR_CTRL;
	localparam logic [11:0] STAT = dcdp_pkg::DCDP_ADDR_STATUS;

	dcdp_port dcdp_port_i (.clk_in(clk_in), .resetn_in(resetn_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .sample_valid_in(sample_valid_in),
		.sample_data_in(sample_data_in), .sample_ready_out(sample_ready_out),
		.up_valid_in(up_valid), .up_data_in(up_data), .up_last_in(up_last),
		.up_ready_out(up_ready), .dn_valid_out(dn_valid), .dn_data_out(dn_data),
		.dn_last_out(dn_last), .dn_ready_in(dn_ready), .bp_valid_out(bp_valid),
		.bp_data_out(bp_data), .bp_ready_in(bp_ready), .chain_hold_out(hold_out),
		.chain_resync_out(resync_out));
	dcdp_chain_model dcdp_chain_model_i (.clk_in(clk_in), .resetn_in(resetn_in), .go_in(go),
		.cnt_in(cnt), .base_in(base), .slow_in(slow), .up_valid_out(up_valid),
		.up_data_out(up_data), .up_last_out(up_last), .up_ready_in(up_ready),
		.dn_valid_in(dn_valid), .dn_data_in(dn_data), .dn_last_in(dn_last),
		.dn_ready_out(dn_ready));

	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end

	always @(posedge clk_in)
		if (bp_valid === 1'b1 && bp_ready === 1'b1)
			bp_q.push_back(bp_data);

	task end_sim;
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim

	task give_up;
		miscompares++;
		$display("Wait limit reached at %0t", $time);
		end_sim();
	endtask : give_up

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		t = 0;
		do
		begin
			@(posedge clk_in);
			t++;
		end
		while (pready_out !== 1'b1 && t < 50);
		if (t >= 50)
			give_up();
		rdata = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(rdata, e);
	endtask : rd

	task push(input int n, input logic [31:0] b);
		int t;
		for (int k = 0; k < n; k++)
		begin
			sample_valid_in <= 1'b1;
			sample_data_in <= b + 32'(k);
			t = 0;
			do
			begin
				@(posedge clk_in);
				t++;
			end
			while (sample_ready_out !== 1'b1 && t < 200);
			if (t >= 200)
				give_up();
		end
		sample_valid_in <= 1'b0;
	endtask : push

	task send(input logic [7:0] n, input logic [31:0] b);
		cnt <= n;
		base <= b;
		go <= 1'b1;
		@(posedge clk_in);
		go <= 1'b0;
	endtask : send

	// Waits for n words on the chain (which 0) or on the backplane (which 1).
	task wait_for(input int which, input int n);
		for (int t = 0; t < 500; t++)
		begin
			if ((which == 0 ? dcdp_chain_model_i.n_got : bp_q.size()) >= n)
				return;
			@(posedge clk_in);
		end
		give_up();
	endtask : wait_for

	task pair(input int k, input logic [31:0] b, input int n, input logic l);
		for (int i = 0; i < n; i++)
			`CHK(dcdp_chain_model_i.got[k + i], {l && i == n - 1, b + 32'(i)});
	endtask : pair

	initial
	begin
		{psel_in, penable_in, pwrite_in, sample_valid_in, go, slow} = 6'h00;
		{paddr_in, pwdata_in, sample_data_in, base, cnt} = '0;
		bp_ready = 1'b1;
		resetn_in = 1'b0;
		repeat (6) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd(CTRL, 32'h0000_000B);
		rd(STAT, 32'h0000_000C);
		rd(dcdp_pkg::DCDP_ADDR_BLKLEN, 32'h0000_0010);
		wr(12'h010, 32'h0000_0000);
		`CHK(rerr, 1'b1);
		`CHK(hold_out, 1'b1);
		send(8'h02, 32'hA000_0000);
		repeat (10) @(posedge clk_in);
		`CHK(dcdp_chain_model_i.n_got, 0);
		wr(CTRL, 32'h0000_0007);
		wait_for(0, 2);
		pair(0, 32'hA000_0000, 2, 1'b1);
		`CHK(hold_out, 1'b0);
		wr(STAT, 32'h0000_0006);
		rd(STAT, 32'h0000_0008);
		wr(CTRL, 32'h0000_000F);
		rd(STAT, 32'h0000_000C);
		`CHK(resync_out, 1'b1);
		wr(CTRL, 32'h0000_0007);
		wr(STAT, 32'h0000_0004);
		slow <= 1'b1;
		send(8'h04, 32'hB000_0000);
		wait_for(0, 6);
		pair(2, 32'hB000_0000, 4, 1'b1);
		wr(dcdp_pkg::DCDP_ADDR_BLKLEN, 32'h0000_0003);
		push(3, 32'hC000_0000);
		wr(CTRL, 32'h0000_0004);
		wr(CTRL, 32'h0000_0014);
		send(8'h02, 32'hD000_0000);
		wait_for(0, 9);
		pair(6, 32'hC000_0000, 3, 1'b1);
		`CHK(up_ready, 1'b0);
		rd(STAT, 32'h0000_0009);
		wr(CTRL, 32'h0000_0007);
		rd(STAT, 32'h0000_000A);
		wait_for(0, 11);
		pair(9, 32'hD000_0000, 2, 1'b1);
		wr(dcdp_pkg::DCDP_ADDR_BLKLEN, 32'h0000_0002);
		wr(STAT, 32'h0000_0002);
		wr(CTRL, 32'h0000_0006);
		wr(CTRL, 32'h0000_0016);
		push(2, 32'h1111_0000);
		send(8'h02, 32'h2222_0000);
		wait_for(0, 15);
		pair(11, 32'h1111_0000, 2, 1'b0);
		pair(13, 32'h2222_0000, 2, 1'b1);
		wr(CTRL, 32'h0000_0005);
		rd(STAT, 32'h0000_000A);
		wr(STAT, 32'h0000_0002);
		wr(CTRL, 32'h0000_0015);
		push(2, 32'hE000_0000);
		send(8'h02, 32'hF000_0000);
		wait_for(0, 19);
		pair(15, 32'hF000_0000, 2, 1'b0);
		pair(17, 32'hE000_0000, 2, 1'b1);
		wr(CTRL, 32'h0000_0005);
		rd(STAT, 32'h0000_0009);
		// The backplane stalls holding one word while the FIFO fills, then drains it all.
		bp_ready <= 1'b0;
		wr(CTRL, 32'h0000_0001);
		rd(CTRL, 32'h0000_0001);
		push(17, 32'h3333_0000);
		repeat (3) @(posedge clk_in);
		`CHK(sample_ready_out, 1'b0);
		rd(STAT, 32'h0000_0011);
		bp_ready <= 1'b1;
		wait_for(1, 17);
		for (int i = 0; i < 17; i++)
			`CHK(bp_q[i], 32'h3333_0000 + 32'(i));
		`CHK(dcdp_chain_model_i.n_got, 19);
		rd(STAT, 32'h0000_0009);
		wr(CTRL, 32'h0000_0005);
		rd(CTRL, 32'h0000_0005);
		end_sim();
	end
endmodule : tb_top
